// [biuc_ctrl.sv]
// external bus interface control: cycle sequencing, byte enables,
// transceiver control, hold arbitration, strap, dma and int0 inputs
// assumes a core that holds req_valid_i until cycle_done_o
//
// How it works
// - async ready is accepted asynchronously, synchronised
// - tied-low async ready defers to sync ready
// - upper enable plus bit0 encode transfer width
// - upper enable held from T1 through T3/waits
// - upper enable floats in hold, reset, test
// - refresh drives upper enable and bit0 high
// - strap high: drop bits suppress address phase
// - strap low: always address phase, normal status
// - strap latched shortly after reset, kept
// - clock outputs selectable, run in reset/hold
// - transceiver enable per cycle, off on turn
// - dma requests synchronised, never latched
// - direction high transmit, low receive, floats
// - hold: finish cycle, grant, float, selects high
// - hold withdrawn: grant drops, bus resumes
// - refresh need drops grant early
// - hold yields only to pending refresh
// - grant output floats in test mode
// - int0 synchronised, edge or level, maskable
// - separate high and low write strobes
`timescale 1ns/1ps
`include "biuc_regs.svh"
module biuc_ctrl #(
  parameter int PS_DIV = 8
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire biuc_pkg::biuc_cyc_t req_type_i,
  input wire biuc_pkg::biuc_bytes_t req_bytes_i,
  input wire logic req_low_mem_i,
  input wire logic req_up_mem_i,
  input wire logic low_mem_drop_i,
  input wire logic up_mem_drop_i,
  input wire logic async_ready_in_i,
  input wire logic sync_ready_in_i,
  input wire logic hold_req_i,
  input wire logic once_mode_i,
  input wire logic addr_phase_strap_i,
  input wire biuc_pkg::biuc_clksel_t clk_sel_a_i,
  input wire biuc_pkg::biuc_clksel_t clk_sel_b_i,
  input wire logic [1:0] dma_request_in_i,
  input wire logic int0_req_i,
  input wire logic int0_mask_i,
  input wire logic int0_level_i,
  input wire logic int0_ack_i,
  output logic cycle_done_o,
  output logic upper_byte_enable_n_o,
  output logic upper_byte_enable_oe_o,
  output logic ad0_o,
  output logic addr_phase_en_o,
  output logic low_byte_write_strobe_n_o,
  output logic high_byte_write_strobe_n_o,
  output logic write_strobe_oe_o,
  output logic xcvr_direction_o,
  output logic xcvr_direction_oe_o,
  output logic transceiver_output_enable_n_o,
  output logic transceiver_output_enable_oe_o,
  output logic bus_grant_ack_o,
  output logic bus_grant_ack_oe_o,
  output logic chip_select_force_high_o,
  output logic bus_float_o,
  output logic addr_phase_mode_o,
  output logic status_pins_normal_o,
  output logic sys_clock_out_a_o,
  output logic sys_clock_out_a_oe_o,
  output logic sys_clock_out_b_o,
  output logic sys_clock_out_b_oe_o,
  output logic [1:0] dma_request_o,
  output logic int0_pending_o
);

  // ----------------------------------------------------------------
  // input synchronisers and clock outputs
  // ----------------------------------------------------------------
  logic [`BIUC_SY_W-1:0] sy;

  biuc_sync #(.W(`BIUC_SY_W)) u_sync (
    .clock_i(clock_i),
    .d_i({int0_req_i, dma_request_in_i, hold_req_i, sync_ready_in_i, async_ready_in_i, addr_phase_strap_i}),
    .q_o(sy)
  );

  biuc_clkout #(.PS_DIV(PS_DIV)) u_clk (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .sel_a_i(clk_sel_a_i),
    .sel_b_i(clk_sel_b_i),
    .clk_a_o(sys_clock_out_a_o),
    .clk_a_oe_o(sys_clock_out_a_oe_o),
    .clk_b_o(sys_clock_out_b_o),
    .clk_b_oe_o(sys_clock_out_b_oe_o)
  );

  wire logic hold_s = sy[`BIUC_SY_HOLD];
  // either ready ends the wait, so a low-tied async pin defers to sync ready
  wire logic ready_s = sy[`BIUC_SY_ASYNC_READY_IN] | sy[`BIUC_SY_SYNC_READY_IN];

  // ----------------------------------------------------------------
  // address phase strap
  // ----------------------------------------------------------------
  logic [1:0] strap_cnt_q;
  logic strap_q;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      strap_cnt_q <= 2'h0;
    end else if (strap_cnt_q != `BIUC_STRAP_END) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end

  // only a reset may change the latched mode
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      strap_q <= `BIUC_STRAP_RST;
    end else if (strap_cnt_q == `BIUC_STRAP_AT) begin
      strap_q <= sy[`BIUC_SY_STRAP];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      addr_phase_mode_o <= `BIUC_STRAP_RST;
      status_pins_normal_o <= 1'h0;
    end else begin
      addr_phase_mode_o <= strap_q;
      status_pins_normal_o <= ~strap_q;
    end
  end

  // ----------------------------------------------------------------
  // cycle sequencer and hold arbitration
  // ----------------------------------------------------------------
  biuc_pkg::biuc_state_t state_q;
  biuc_pkg::biuc_state_t state_d;
  biuc_pkg::biuc_cyc_t cyc_q;
  biuc_pkg::biuc_bytes_t bytes_q;
  logic refresh_pend;
  logic grant_d;
  logic float_d;
  logic active_d;
  logic is_wr;
  logic dir_d;

  assign refresh_pend = req_valid_i && (req_type_i == biuc_pkg::BIUC_REFRESH);
  assign is_wr = (cyc_q == biuc_pkg::BIUC_MEM_WR) || (cyc_q == biuc_pkg::BIUC_IO_WR);

  always_comb begin
    state_d = state_q;
    case (state_q)
      biuc_pkg::BIUC_IDLE: begin
        // refresh outranks hold, hold outranks everything else
        if (hold_s && !refresh_pend) begin
          state_d = biuc_pkg::BIUC_HOLD;
        end else if (req_valid_i && !cycle_done_o) begin
          state_d = biuc_pkg::BIUC_T1;
        end
      end
      biuc_pkg::BIUC_T1: state_d = biuc_pkg::BIUC_T2;
      biuc_pkg::BIUC_T2: state_d = biuc_pkg::BIUC_T3;
      biuc_pkg::BIUC_T3: begin
        if (ready_s) begin
          state_d = biuc_pkg::BIUC_T4;
        end
      end
      biuc_pkg::BIUC_T4: state_d = biuc_pkg::BIUC_IDLE;
      biuc_pkg::BIUC_HOLD: begin
        if (!hold_s) begin
          state_d = biuc_pkg::BIUC_IDLE;
        end
      end
      default: state_d = biuc_pkg::BIUC_IDLE;
    endcase
  end

  // grant drops early when a refresh waits, bus stays released until hold goes
  assign grant_d = (state_d == biuc_pkg::BIUC_HOLD) && hold_s && !refresh_pend;
  assign float_d = (state_d == biuc_pkg::BIUC_HOLD) || once_mode_i;
  assign active_d = (state_d == biuc_pkg::BIUC_T1) || (state_d == biuc_pkg::BIUC_T2) ||
                    (state_d == biuc_pkg::BIUC_T3);

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_q <= biuc_pkg::BIUC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cyc_q <= biuc_pkg::BIUC_MEM_RD;
      bytes_q <= biuc_pkg::BIUC_WORD;
    end else if (state_q == biuc_pkg::BIUC_IDLE && state_d == biuc_pkg::BIUC_T1) begin
      cyc_q <= req_type_i;
      bytes_q <= req_bytes_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      bus_grant_ack_o <= 1'h0;
      bus_grant_ack_oe_o <= 1'h0;
      chip_select_force_high_o <= 1'h0;
      bus_float_o <= 1'h1;
      cycle_done_o <= 1'h0;
    end else begin
      bus_grant_ack_o <= grant_d;
      bus_grant_ack_oe_o <= ~once_mode_i;
      chip_select_force_high_o <= state_d == biuc_pkg::BIUC_HOLD;
      bus_float_o <= float_d;
      cycle_done_o <= state_d == biuc_pkg::BIUC_T4;
    end
  end

  // ----------------------------------------------------------------
  // byte enables, address phase and write strobes
  // ----------------------------------------------------------------
  logic ube_n;
  logic ad0;
  logic drop;

  always_comb begin
    ube_n = `BIUC_UBE_IDLE;
    ad0 = 1'h0;
    if (req_type_i == biuc_pkg::BIUC_REFRESH) begin
      ube_n = 1'h1;
      ad0 = 1'h1;
    end else begin
      case (req_bytes_i)
        biuc_pkg::BIUC_WORD: begin
          ube_n = 1'h0;
          ad0 = 1'h0;
        end
        biuc_pkg::BIUC_HIGH: begin
          ube_n = 1'h0;
          ad0 = 1'h1;
        end
        biuc_pkg::BIUC_LOW: begin
          ube_n = 1'h1;
          ad0 = 1'h0;
        end
        default: begin
          ube_n = `BIUC_UBE_IDLE;
          ad0 = 1'h0;
        end
      endcase
    end
  end

  assign drop = strap_q && ((req_low_mem_i && low_mem_drop_i) || (req_up_mem_i && up_mem_drop_i));

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      upper_byte_enable_n_o <= `BIUC_UBE_IDLE;
      ad0_o <= 1'h0;
      addr_phase_en_o <= 1'h0;
    end else if (state_q == biuc_pkg::BIUC_IDLE && state_d == biuc_pkg::BIUC_T1) begin
      upper_byte_enable_n_o <= ube_n;
      ad0_o <= ad0;
      addr_phase_en_o <= ~drop;
    end else begin
      addr_phase_en_o <= 1'h0;
      if (!active_d) begin
        upper_byte_enable_n_o <= `BIUC_UBE_IDLE;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      upper_byte_enable_oe_o <= 1'h0;
      write_strobe_oe_o <= 1'h0;
      low_byte_write_strobe_n_o <= 1'h1;
      high_byte_write_strobe_n_o <= 1'h1;
    end else begin
      upper_byte_enable_oe_o <= ~float_d;
      write_strobe_oe_o <= ~float_d;
      low_byte_write_strobe_n_o <= ~((state_d == biuc_pkg::BIUC_T2 || state_d == biuc_pkg::BIUC_T3) &&
                                     is_wr && (bytes_q != biuc_pkg::BIUC_HIGH));
      high_byte_write_strobe_n_o <= ~((state_d == biuc_pkg::BIUC_T2 || state_d == biuc_pkg::BIUC_T3) &&
                                      is_wr && (bytes_q != biuc_pkg::BIUC_LOW));
    end
  end

  // ----------------------------------------------------------------
  // transceiver direction and enable
  // ----------------------------------------------------------------
  assign dir_d = (req_type_i == biuc_pkg::BIUC_MEM_WR) || (req_type_i == biuc_pkg::BIUC_IO_WR);

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      xcvr_direction_o <= `BIUC_DIR_RX;
      xcvr_direction_oe_o <= 1'h0;
      transceiver_output_enable_n_o <= 1'h1;
      transceiver_output_enable_oe_o <= 1'h0;
    end else begin
      if (state_q == biuc_pkg::BIUC_IDLE && state_d == biuc_pkg::BIUC_T1) begin
        xcvr_direction_o <= dir_d;
      end
      xcvr_direction_oe_o <= ~float_d;
      transceiver_output_enable_oe_o <= ~float_d;
      // enable opens only after the direction has settled in T1
      transceiver_output_enable_n_o <= ~(state_d == biuc_pkg::BIUC_T2 || state_d == biuc_pkg::BIUC_T3);
    end
  end

  // ----------------------------------------------------------------
  // dma requests and int0
  // ----------------------------------------------------------------
  logic int0_prev_q;
  logic int0_edge_q;
  logic int0_s;

  assign int0_s = sy[`BIUC_SY_INT0];

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      dma_request_o <= 2'h0;
    end else begin
      dma_request_o <= sy[`BIUC_SY_DMA +: 2];
    end
  end

  // a rise arriving with the acknowledge is kept: set beats clear
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      int0_prev_q <= 1'h0;
      int0_edge_q <= 1'h0;
    end else begin
      int0_prev_q <= int0_s;
      if (int0_s && !int0_prev_q) begin
        int0_edge_q <= 1'h1;
      end else if (int0_ack_i) begin
        int0_edge_q <= 1'h0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      int0_pending_o <= 1'h0;
    end else begin
      int0_pending_o <= ~int0_mask_i & (int0_level_i ? int0_s : int0_edge_q);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_enter;
    state_q == biuc_pkg::BIUC_IDLE && state_d == biuc_pkg::BIUC_T1 && !float_d;
  endsequence
  sequence s_ube_held;
    (!upper_byte_enable_n_o)[*3];
  endsequence

  property p_ube_span;
    s_enter and (req_type_i != biuc_pkg::BIUC_REFRESH && req_bytes_i != biuc_pkg::BIUC_LOW) |=> s_ube_held;
  endproperty
  a_ube_span: assert property (p_ube_span) else $error("upper enable not held T1..T3");

  property p_refresh_enc;
    s_enter and (req_type_i == biuc_pkg::BIUC_REFRESH) |=> upper_byte_enable_n_o && ad0_o;
  endproperty
  a_refresh_enc: assert property (p_refresh_enc) else $error("refresh encoding wrong");

  property p_ube_float;
    bus_grant_ack_o |-> !upper_byte_enable_oe_o && !xcvr_direction_oe_o && chip_select_force_high_o;
  endproperty
  a_ube_float: assert property (p_ube_float) else $error("bus not released under grant");

  property p_den_turn;
    $changed(xcvr_direction_o) |-> transceiver_output_enable_n_o;
  endproperty
  a_den_turn: assert property (p_den_turn) else $error("enable active across turn");

  property p_ready_end;
    state_q == biuc_pkg::BIUC_T3 && ready_s |=> (state_q == biuc_pkg::BIUC_T4 && cycle_done_o) ##1 !cycle_done_o;
  endproperty
  a_ready_end: assert property (p_ready_end) else $error("ready did not end cycle");

  property p_hold_release;
    bus_grant_ack_o && !hold_s |=> !bus_grant_ack_o;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("grant kept after hold withdrawn");

  property p_refresh_first;
    state_q == biuc_pkg::BIUC_IDLE && hold_s && refresh_pend |=> state_q != biuc_pkg::BIUC_HOLD;
  endproperty
  a_refresh_first: assert property (p_refresh_first) else $error("hold beat pending refresh");

  property p_strap_kept;
    strap_cnt_q == `BIUC_STRAP_END |=> $stable(strap_q);
  endproperty
  a_strap_kept: assert property (p_strap_kept) else $error("strap mode changed");

  property p_early_drop;
    bus_grant_ack_o && refresh_pend |=> !bus_grant_ack_o;
  endproperty
  a_early_drop: assert property (p_early_drop) else $error("grant not dropped for refresh");

endmodule : biuc_ctrl

// [biuc_regs.svh]
// constants for the external bus interface control block
// assumes inclusion by bare name from every design file that needs it
`ifndef BIUC_REGS_SVH
`define BIUC_REGS_SVH

// ----------------------------------------------------------------
// strap sampling window after reset release
// ----------------------------------------------------------------
`define BIUC_STRAP_RST 1'h1
`define BIUC_STRAP_AT 2'h1
`define BIUC_STRAP_END 2'h3

// ----------------------------------------------------------------
// upper enable idle level and transceiver direction levels (receive / transmit)
// ----------------------------------------------------------------
`define BIUC_UBE_IDLE 1'h1
`define BIUC_DIR_RX 1'h0
`define BIUC_DIR_TX 1'h1

// ----------------------------------------------------------------
// synchroniser input positions
// ----------------------------------------------------------------
`define BIUC_SY_STRAP 0
`define BIUC_SY_ASYNC_READY_IN 1
`define BIUC_SY_SYNC_READY_IN 2
`define BIUC_SY_HOLD 3
`define BIUC_SY_DMA 4
`define BIUC_SY_INT0 6
`define BIUC_SY_W 7

`endif

// [biuc_pkg.sv]
// types shared by the bus interface control block
// assumes nothing of its surroundings
package biuc_pkg;

  typedef enum logic [2:0] {
    BIUC_IDLE = 3'h0,
    BIUC_T1 = 3'h1,
    BIUC_T2 = 3'h2,
    BIUC_T3 = 3'h3,
    BIUC_T4 = 3'h4,
    BIUC_HOLD = 3'h5
  } biuc_state_t;

  typedef enum logic [2:0] {
    BIUC_MEM_RD = 3'h0,
    BIUC_MEM_WR = 3'h1,
    BIUC_IO_RD = 3'h2,
    BIUC_IO_WR = 3'h3,
    BIUC_INTA = 3'h4,
    BIUC_REFRESH = 3'h5
  } biuc_cyc_t;

  typedef enum logic [1:0] {
    BIUC_WORD = 2'h0,
    BIUC_HIGH = 2'h1,
    BIUC_LOW = 2'h2
  } biuc_bytes_t;

  typedef enum logic [1:0] {
    BIUC_CLK_FUND = 2'h0,
    BIUC_CLK_PSAVE = 2'h1,
    BIUC_CLK_OFF = 2'h2
  } biuc_clksel_t;

endpackage : biuc_pkg

// [biuc_sync.sv]
// three-stage pin synchroniser, one lane per bit
// assumes inputs come from outside the clock domain; no reset so it
// keeps sampling while the block is held in reset
`timescale 1ns/1ps
module biuc_sync #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_lane
      logic s1_q;
      logic s2_q;
      logic s3_q;
      always_ff @(posedge clock_i) begin
        s1_q <= d_i[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
      end
      // a change is only believed once two later stages agree
      always_ff @(posedge clock_i) begin
        if (s2_q == s3_q) begin
          q_o[g] <= s3_q;
        end
      end
    end
  endgenerate

endmodule : biuc_sync

// [biuc_clkout.sv]
// two system clock outputs: fundamental, power-save or floated
// assumes the fundamental output rate is half the core clock
`timescale 1ns/1ps
module biuc_clkout #(
  parameter int PS_DIV = 8
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire biuc_pkg::biuc_clksel_t sel_a_i,
  input wire biuc_pkg::biuc_clksel_t sel_b_i,
  output logic clk_a_o,
  output logic clk_a_oe_o,
  output logic clk_b_o,
  output logic clk_b_oe_o
);

  logic fund_q;
  logic ps_q;
  logic [15:0] cnt_q;
  logic [1:0] clk_q;
  logic [1:0] oe_q;
  biuc_pkg::biuc_clksel_t sel[2];

  assign sel[0] = sel_a_i;
  assign sel[1] = sel_b_i;

  // the fundamental toggle ignores reset so the outputs keep running
  always_ff @(posedge clock_i) begin
    if (fund_q) begin
      fund_q <= 1'h0;
    end else begin
      fund_q <= 1'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cnt_q <= 16'h0000;
      ps_q <= 1'h0;
    end else if (cnt_q == 16'(PS_DIV - 1)) begin
      cnt_q <= 16'h0000;
      ps_q <= ~ps_q;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // during reset both outputs fall back to the fundamental rate
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_out
      always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
          clk_q[g] <= fund_q;
          oe_q[g] <= 1'h1;
        end else begin
          clk_q[g] <= (sel[g] == biuc_pkg::BIUC_CLK_PSAVE) ? ps_q : fund_q;
          oe_q[g] <= (sel[g] == biuc_pkg::BIUC_CLK_FUND) || (sel[g] == biuc_pkg::BIUC_CLK_PSAVE);
        end
      end
    end
  endgenerate

  assign clk_a_o = clk_q[0];
  assign clk_a_oe_o = oe_q[0];
  assign clk_b_o = clk_q[1];
  assign clk_b_oe_o = oe_q[1];

endmodule : biuc_clkout

// [biuc_mem_model.sv]
// memory / io partner: answers bus cycles on the ready pins
// assumes busy_i is the core request level and done_i the cycle end pulse
`timescale 1ns/1ps
module biuc_mem_model (
  input wire logic clock_i,
  input wire logic busy_i,
  input wire logic done_i,
  input wire logic [1:0] mode_i,
  input wire logic [1:0] wait_i,
  output logic async_ready_o,
  output logic sync_ready_o
);
  logic [3:0] cnt_q;
  logic rdy;
  logic arise;
  initial cnt_q = 4'h0;
  initial arise = 1'b0;
  always @(posedge clock_i) begin
    if (busy_i && !done_i) cnt_q <= cnt_q + 4'h1;
    else cnt_q <= 4'h0;
  end
  assign rdy = busy_i && !done_i && (cnt_q > {2'h0, wait_i});
  // rise lands off the edge, fall only at the clock edge that ends the cycle
  always @(rdy) begin
    if (rdy) arise <= #3 1'b1;
    else arise = 1'b0;
  end
  // mode 0: async tied low, 1: async only, 2: async tied high
  assign async_ready_o = (mode_i == 2'h2) | ((mode_i == 2'h1) & arise);
  assign sync_ready_o = (mode_i == 2'h0) & rdy;
endmodule : biuc_mem_model

// [test_biuc_ctrl.sv]
// self-checking bench for the bus interface control block
// assumes the memory partner model and the design package are compiled first
`timescale 1ns/1ps
module test_biuc_ctrl;
  logic clock_i, reset_n_i, req_valid_i, req_low_mem_i, req_up_mem_i, low_mem_drop_i, up_mem_drop_i;
  logic async_ready_in_i, sync_ready_in_i, hold_req_i, once_mode_i, addr_phase_strap_i;
  biuc_pkg::biuc_cyc_t req_type_i;
  biuc_pkg::biuc_bytes_t req_bytes_i;
  biuc_pkg::biuc_clksel_t clk_sel_a_i, clk_sel_b_i;
  logic [1:0] dma_request_in_i, dma_request_o, mm_mode, mm_wait;
  logic int0_req_i, int0_mask_i, int0_level_i, int0_ack_i, int0_pending_o;
  logic cycle_done_o, upper_byte_enable_n_o, upper_byte_enable_oe_o, ad0_o, addr_phase_en_o;
  logic low_byte_write_strobe_n_o, high_byte_write_strobe_n_o, write_strobe_oe_o, xcvr_direction_o;
  logic xcvr_direction_oe_o, transceiver_output_enable_n_o, transceiver_output_enable_oe_o;
  logic bus_grant_ack_o, bus_grant_ack_oe_o, chip_select_force_high_o, bus_float_o;
  logic addr_phase_mode_o, status_pins_normal_o, sys_clock_out_a_o, sys_clock_out_a_oe_o;
  logic sys_clock_out_b_o, sys_clock_out_b_oe_o, strap_v, ape_seen, a;
  logic [5:0] snap;
  logic [6:0] q_e[$], q_m[$];
  int failures, n_tests, i, k;

  biuc_ctrl #(.PS_DIV(2)) dut (.*);
  biuc_mem_model mem (.clock_i(clock_i), .busy_i(req_valid_i), .done_i(cycle_done_o), .mode_i(mm_mode),
    .wait_i(mm_wait), .async_ready_o(async_ready_in_i), .sync_ready_o(sync_ready_in_i));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // ----------------------------------------------------------------
  // compare, report, verdict
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  // snapshot of the last T3 is judged when the cycle end pulse shows
  always @(negedge clock_i) begin
    if (cycle_done_o === 1'b1) begin
      if (q_e.size() == 0) chk(8'h01, 8'h00);
      else chk({1'b0, {ape_seen, snap} & q_m[0]}, {1'b0, q_e[0] & q_m[0]});
      if (q_e.size() != 0) begin
        void'(q_e.pop_front());
        void'(q_m.pop_front());
      end
      ape_seen = 1'b0;
    end else if (addr_phase_en_o === 1'b1) ape_seen = 1'b1;
    snap = {upper_byte_enable_n_o, ad0_o, xcvr_direction_o, high_byte_write_strobe_n_o,
      low_byte_write_strobe_n_o, transceiver_output_enable_n_o};
  end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic rst(input logic s);
    reset_n_i = 1'b0;
    addr_phase_strap_i = s;
    strap_v = s;
    ape_seen = 1'b0;
    repeat (3) @(negedge clock_i);
    chk({4'h0, upper_byte_enable_oe_o, xcvr_direction_oe_o, transceiver_output_enable_oe_o, bus_grant_ack_oe_o},
      8'h00);
    chk({6'h0, bus_float_o, sys_clock_out_a_oe_o & sys_clock_out_b_oe_o}, 8'h03);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clock_i);
    chk({6'h0, addr_phase_mode_o, status_pins_normal_o}, {6'h0, s, !s});
    addr_phase_strap_i = !s;
    repeat (4) @(negedge clock_i);
    chk({7'h0, addr_phase_mode_o}, {7'h0, s});
  endtask : rst

  task automatic cyc(input int t, input int b);
    logic [6:0] e;
    logic w;
    int n;
    w = (t == 1 || t == 3);
    e[6] = !(strap_v && ((req_low_mem_i && low_mem_drop_i) || (req_up_mem_i && up_mem_drop_i)));
    e[5:4] = (t == 5) ? 2'h3 : (b == 0) ? 2'h0 : (b == 1) ? 2'h1 : 2'h2;
    e[3:0] = {w, !(w && b != 2), !(w && b != 1), 1'b0};
    q_e.push_back(e);
    q_m.push_back((t == 5) ? 7'h30 : 7'h7F);
    req_type_i = biuc_pkg::biuc_cyc_t'(t);
    req_bytes_i = biuc_pkg::biuc_bytes_t'(b);
    req_valid_i = 1'b1;
    for (n = 0; n < 80 && cycle_done_o !== 1'b1; n++) @(negedge clock_i);
    chk({7'h0, cycle_done_o}, 8'h01);
    req_valid_i = 1'b0;
    @(negedge clock_i);
  endtask : cyc

  task automatic wgrant(input logic v);
    int n;
    for (n = 0; n < 40 && bus_grant_ack_o !== v; n++) @(negedge clock_i);
    chk({7'h0, bus_grant_ack_o}, {7'h0, v});
  endtask : wgrant

  initial begin
    #300000;
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    conclude();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    failures = 0;
    n_tests = 0;
    {req_valid_i, req_low_mem_i, req_up_mem_i, low_mem_drop_i, up_mem_drop_i, hold_req_i, once_mode_i} = 7'h00;
    {int0_req_i, int0_mask_i, int0_level_i, int0_ack_i, mm_mode, mm_wait, dma_request_in_i} = 10'h000;
    req_type_i = biuc_pkg::BIUC_MEM_RD;
    req_bytes_i = biuc_pkg::BIUC_WORD;
    clk_sel_a_i = biuc_pkg::BIUC_CLK_FUND;
    clk_sel_b_i = biuc_pkg::BIUC_CLK_FUND;
    k = $urandom(57);
    rst(1'b0);
    // every cycle kind and byte width, strap low then high after a mid-run reset
    for (i = 0; i < 36; i++) begin
      if (i == 18) rst(1'b1);
      {req_low_mem_i, req_up_mem_i, low_mem_drop_i, up_mem_drop_i} = 4'($urandom);
      mm_mode = 2'($urandom % 3);
      mm_wait = 2'($urandom);
      cyc(i % 6, (i / 6) % 3);
    end
    // hold raised mid cycle: the cycle ends first, then the bus floats
    fork
      cyc(1, 0);
      begin
        repeat (2) @(negedge clock_i);
        hold_req_i = 1'b1;
      end
    join
    wgrant(1'b1);
    chk({2'h0, chip_select_force_high_o, bus_float_o, upper_byte_enable_oe_o, write_strobe_oe_o,
      xcvr_direction_oe_o, transceiver_output_enable_oe_o}, 8'h30);
    a = sys_clock_out_a_o;
    @(negedge clock_i);
    chk({7'h0, sys_clock_out_a_o}, {7'h0, !a});
    hold_req_i = 1'b0;
    wgrant(1'b0);
    hold_req_i = 1'b1;
    wgrant(1'b1);
    // refresh need takes the grant back; the master then lets go
    fork
      cyc(5, 0);
      begin
        wgrant(1'b0);
        hold_req_i = 1'b0;
      end
    join
    once_mode_i = 1'b1;
    repeat (2) @(negedge clock_i);
    chk({6'h0, bus_grant_ack_oe_o, upper_byte_enable_oe_o}, 8'h00);
    once_mode_i = 1'b0;
    clk_sel_a_i = biuc_pkg::BIUC_CLK_OFF;
    clk_sel_b_i = biuc_pkg::BIUC_CLK_PSAVE;
    repeat (3) @(negedge clock_i);
    chk({6'h0, sys_clock_out_a_oe_o, sys_clock_out_b_oe_o}, 8'h01);
    k = 0;
    for (i = 0; i < 8; i++) begin
      a = sys_clock_out_b_o;
      @(negedge clock_i);
      if (sys_clock_out_b_o !== a) k++;
    end
    chk(8'(k), 8'h04);
    clk_sel_a_i = biuc_pkg::BIUC_CLK_FUND;
    for (i = 0; i < 4; i++) begin
      dma_request_in_i = 2'($urandom);
      repeat (5) @(negedge clock_i);
      chk({6'h0, dma_request_o}, {6'h0, dma_request_in_i});
    end
    // edge request is remembered after the pin drops, until acknowledged
    int0_req_i = 1'b1;
    repeat (2) @(negedge clock_i);
    int0_req_i = 1'b0;
    repeat (6) @(negedge clock_i);
    chk({7'h0, int0_pending_o}, 8'h01);
    int0_ack_i = 1'b1;
    @(negedge clock_i);
    int0_ack_i = 1'b0;
    repeat (2) @(negedge clock_i);
    chk({7'h0, int0_pending_o}, 8'h00);
    {int0_level_i, int0_mask_i, int0_req_i} = 3'h7;
    repeat (6) @(negedge clock_i);
    chk({7'h0, int0_pending_o}, 8'h00);
    int0_mask_i = 1'b0;
    repeat (2) @(negedge clock_i);
    chk({7'h0, int0_pending_o}, 8'h01);
    int0_req_i = 1'b0;
    repeat (6) @(negedge clock_i);
    chk({7'h0, int0_pending_o}, 8'h00);
    conclude();
  end
endmodule : test_biuc_ctrl
